/* File: core/dgp_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dgp_map.svh"

// Function
// [RULE1] Port 9 direction bits reset to input; input feeds second UART receive.
// [RULE2] Port 9 function bit 1 drives second UART transmit instead of latch.
// [RULE3] Port 9 output type: 0 push-pull, 1 open-drain, reset 0.
// [RULE4] Port 9 pull-up acts only for inputs or open-drain outputs.
// [RULE5] Port 9 pin read gives pin level, or 0 for push-pull outputs.
// [RULE6] Port B uses bits 7..4, direction per bit, reset to input.
// [RULE7] Port B latch sets driven level, resets 0, readable and writable.
// [RULE8] Port B function bits 6..4 select serial clock, first UART transmit, data out.
// [RULE9] Port B output type: 0 push-pull, 1 open-drain, reset 0.
// [RULE10] Port B pin read gives pin level, or 0 for push-pull outputs.
// [RULE11] Open-drain drives only low; a one leaves the pin undriven.
// [RULE12] Software sets up the pin selector and these registers before use.
// [RULE13] Port 9 latch sets driven level; open-drain one floats; resets 0.
// [RULE14] Unimplemented register bits ignore writes and read zero.
// [RULE15] Pin levels pass a two-flop synchroniser before use.
module dgp_port
    import dgp_pkg::*;
(
    input wire logic clk, // System clock, 200 MHz
    input wire logic reset, // Synchronous, active high
    input wire logic [11:0] addr, // Register address
    input wire logic wr_en, // Write strobe
    input wire logic [7:0] wr_data, // Write data
    input wire logic rd_en, // Read strobe
    output logic [7:0] rd_data, // Read data, one cycle later
    input wire logic [1:0] port9_pin_in, // Port 9 pin levels
    output logic [1:0] port9_pin_out, // Port 9 drive level
    output logic [1:0] port9_pin_oe, // Port 9 driver on
    output logic [1:0] port9_pullup_on, // Port 9 pull-up connected
    input wire logic [7:4] portb_pin_in, // Port B pin levels
    output logic [7:4] portb_pin_out, // Port B drive level
    output logic [7:4] portb_pin_oe, // Port B driver on
    input wire logic uart_second_transmit, // Second UART transmit
    output logic [1:0] uart_second_receive, // Second UART receive per pin
    input wire logic uart_first_transmit, // First UART transmit
    input wire logic serial_clock_line, // Serial clock out
    input wire logic serial_data_out, // Serial data out
    input wire logic portb4_serial_sel, // Bit 4 carries serial data out
    output logic [1:0] uart_first_receive, // First UART receive, bits 5 and 4
    output logic serial_data_in // Serial data in, bit 5
);

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------

    // Pin view for reads: push-pull outputs read back as zero
    function automatic logic [3:0] pin_view(input logic [3:0] dir, input logic [3:0] ot,
                                            input logic [3:0] pin);
        pin_view = pin & ~(dir & ~ot);
    endfunction

    // Driver enable: open-drain lets a one float
    function automatic logic [3:0] drv_oe(input logic [3:0] dir, input logic [3:0] ot,
                                          input logic [3:0] src);
        drv_oe = dir & ~(ot & src);
    endfunction

    // Drive level: open-drain only ever pulls low
    function automatic logic [3:0] drv_out(input logic [3:0] ot, input logic [3:0] src);
        drv_out = src & ~ot;
    endfunction

    // -----------------------------------------------------------------
    // Pin synchroniser
    // -----------------------------------------------------------------
    dgp_state_s st_r;
    dgp_state_s st_nxt;
    logic [5:0] pin_sync;
    logic [1:0] p9_sync;
    logic [3:0] pb_sync;
    logic [3:0] p9_view;
    logic [3:0] pb_view;
    logic [3:0] p9_oe_w;
    logic [3:0] p9_out_w;
    logic [1:0] p9_src;
    logic [3:0] pb_src;

    // [RULE15] two-flop pin capture
    dgp_sync dgp_sync_inst (
        .clk(clk),
        .reset(reset),
        .pin_raw({portb_pin_in, port9_pin_in}),
        .pin_sync(pin_sync)
    );

    assign p9_sync = pin_sync[1:0];
    assign pb_sync = pin_sync[5:2];

    // -----------------------------------------------------------------
    // Drive sources and read views
    // -----------------------------------------------------------------

    // [RULE2] port 9 source select
    assign p9_src = (st_r.p9_fc & {2{uart_second_transmit}}) | (~st_r.p9_fc & st_r.p9_lat);
    // [RULE8] port B source select
    assign pb_src = {st_r.pb_fc[2] ? serial_clock_line : st_r.pb_lat[2],
                     st_r.pb_fc[1] ? uart_first_transmit : st_r.pb_lat[1],
                     st_r.pb_fc[0] ? (portb4_serial_sel ? serial_data_out : uart_first_transmit)
                                   : st_r.pb_lat[0],
                     st_r.pb_lat[3]};
    // Bit order above is 6,5,4,7; reorder to 7..4
    logic [3:0] pb_src_o;
    assign pb_src_o = {pb_src[0], pb_src[3], pb_src[2], pb_src[1]};
    assign pb_view = pin_view(st_r.pb_dir, st_r.pb_ot, pb_sync);
    assign p9_view = pin_view({2'h0, st_r.p9_dir}, {2'h0, st_r.p9_ot}, {2'h0, p9_sync});
    assign p9_oe_w = drv_oe({2'h0, st_r.p9_dir}, {2'h0, st_r.p9_ot}, {2'h0, p9_src});
    assign p9_out_w = drv_out({2'h0, st_r.p9_ot}, {2'h0, p9_src});

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        // [RULE14] only implemented bits are stored
        if (wr_en)
        begin
            case (addr)
                `DGP_OFS_P9_LATCH: st_nxt.p9_lat = wr_data[`DGP_P9_MSB:`DGP_P9_LSB];
                `DGP_OFS_PB_LATCH: st_nxt.pb_lat = wr_data[`DGP_PB_MSB:`DGP_PB_LSB];
                `DGP_OFS_P9_DIRECTION: st_nxt.p9_dir = wr_data[`DGP_P9_MSB:`DGP_P9_LSB];
                `DGP_OFS_PB_DIRECTION: st_nxt.pb_dir = wr_data[`DGP_PB_MSB:`DGP_PB_LSB];
                `DGP_OFS_P9_PULLUP: st_nxt.p9_pu = wr_data[`DGP_P9_MSB:`DGP_P9_LSB];
                `DGP_OFS_P9_FUNCTION: st_nxt.p9_fc = wr_data[`DGP_P9_MSB:`DGP_P9_LSB];
                `DGP_OFS_PB_FUNCTION: st_nxt.pb_fc = wr_data[`DGP_PB_FC_MSB:`DGP_PB_LSB];
                `DGP_OFS_P9_OUT_TYPE: st_nxt.p9_ot = wr_data[`DGP_P9_MSB:`DGP_P9_LSB];
                `DGP_OFS_PB_OUT_TYPE: st_nxt.pb_ot = wr_data[`DGP_PB_MSB:`DGP_PB_LSB];
                default: ;
            endcase
        end
        // Reads answer next cycle; zero when idle or unmapped
        st_nxt.rd_data = `DGP_RST_8;
        if (rd_en)
        begin
            case (addr)
                `DGP_OFS_P9_LATCH: st_nxt.rd_data = {6'h00, st_r.p9_lat};
                // [RULE7] latch reads back
                `DGP_OFS_PB_LATCH: st_nxt.rd_data = {st_r.pb_lat, 4'h0};
                // [RULE5] port 9 pin view
                `DGP_OFS_P9_PIN_READ: st_nxt.rd_data = {6'h00, p9_view[1:0]};
                // [RULE10] port B pin view
                `DGP_OFS_PB_PIN_READ: st_nxt.rd_data = {pb_view, 4'h0};
                `DGP_OFS_P9_DIRECTION: st_nxt.rd_data = {6'h00, st_r.p9_dir};
                `DGP_OFS_PB_DIRECTION: st_nxt.rd_data = {st_r.pb_dir, 4'h0};
                `DGP_OFS_P9_PULLUP: st_nxt.rd_data = {6'h00, st_r.p9_pu};
                `DGP_OFS_P9_FUNCTION: st_nxt.rd_data = {6'h00, st_r.p9_fc};
                `DGP_OFS_PB_FUNCTION: st_nxt.rd_data = {1'h0, st_r.pb_fc, 4'h0};
                `DGP_OFS_P9_OUT_TYPE: st_nxt.rd_data = {6'h00, st_r.p9_ot};
                `DGP_OFS_PB_OUT_TYPE: st_nxt.rd_data = {st_r.pb_ot, 4'h0};
                default: st_nxt.rd_data = `DGP_RST_8;
            endcase
        end
        // [RULE11] open-drain floats a one
        // [RULE13] port 9 latch drive
        // [RULE3] port 9 output type
        st_nxt.p9_oe = p9_oe_w[1:0];
        st_nxt.p9_out = p9_out_w[1:0];
        st_nxt.pb_oe = drv_oe(st_r.pb_dir, st_r.pb_ot, pb_src_o);
        st_nxt.pb_out = drv_out(st_r.pb_ot, pb_src_o);
        // [RULE4] pull-up gating
        st_nxt.p9_pull = st_r.p9_pu & (~st_r.p9_dir | st_r.p9_ot);
        // [RULE1] receive path, idle high when output
        st_nxt.u2_rx = p9_sync | st_r.p9_dir;
        st_nxt.u1_rx = pb_sync[1:0] | st_r.pb_dir[1:0];
        st_nxt.si = pb_sync[1] | st_r.pb_dir[1];
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    // [RULE6] all control resets to input, push-pull, latch zero
    // [RULE9] output type reset
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign rd_data = st_r.rd_data;
    assign port9_pin_out = st_r.p9_out;
    assign port9_pin_oe = st_r.p9_oe;
    assign port9_pullup_on = st_r.p9_pull;
    assign portb_pin_out = st_r.pb_out;
    assign portb_pin_oe = st_r.pb_oe;
    assign uart_second_receive = st_r.u2_rx;
    assign uart_first_receive = st_r.u1_rx;
    assign serial_data_in = st_r.si;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    property p_u2_rx;
        @(posedge clk) disable iff (reset)
        !st_r.p9_dir[0] |=> uart_second_receive[0] == $past(p9_sync[0]);
    endproperty
    a_u2_rx: assert property (p_u2_rx) else $error("second UART receive not fed by pin"); // [RULE1]

    property p_p9_tx;
        @(posedge clk) disable iff (reset)
        st_r.p9_dir[1] && st_r.p9_fc[1] && !st_r.p9_ot[1]
        |=> port9_pin_oe[1] && port9_pin_out[1] == $past(uart_second_transmit);
    endproperty
    a_p9_tx: assert property (p_p9_tx) else $error("port 9 transmit select wrong"); // [RULE2]

    property p_p9_od;
        @(posedge clk) disable iff (reset)
        st_r.p9_ot[0] |=> !port9_pin_out[0];
    endproperty
    a_p9_od: assert property (p_p9_od) else $error("port 9 open-drain drove high"); // [RULE3]

    property p_pull;
        @(posedge clk) disable iff (reset)
        st_r.p9_dir[0] && !st_r.p9_ot[0] |=> !port9_pullup_on[0];
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up on a push-pull output"); // [RULE4]

    property p_p9_read;
        @(posedge clk) disable iff (reset)
        rd_en && addr == `DGP_OFS_P9_PIN_READ && st_r.p9_dir[1] && !st_r.p9_ot[1]
        |=> rd_data[7:1] == 7'h00;
    endproperty
    a_p9_read: assert property (p_p9_read) else $error("port 9 push-pull bit read nonzero"); // [RULE5]

    property p_pb_rst;
        @(posedge clk)
        $fell(reset) |-> st_r.pb_dir == `DGP_RST_4 && st_r.pb_ot == `DGP_RST_4;
    endproperty
    a_pb_rst: assert property (p_pb_rst) else $error("port B control not reset"); // [RULE6]

    property p_pb_lat;
        @(posedge clk) disable iff (reset)
        wr_en && addr == `DGP_OFS_PB_LATCH ##1 rd_en && addr == `DGP_OFS_PB_LATCH && !wr_en
        |=> rd_data == {$past(wr_data[7:4], 2), 4'h0};
    endproperty
    a_pb_lat: assert property (p_pb_lat) else $error("port B latch readback wrong"); // [RULE7]

    property p_sclk;
        @(posedge clk) disable iff (reset)
        st_r.pb_dir[2] && st_r.pb_fc[2] && !st_r.pb_ot[2]
        |=> portb_pin_out[6] == $past(serial_clock_line);
    endproperty
    a_sclk: assert property (p_sclk) else $error("serial clock not on bit 6"); // [RULE8]

    property p_pb_read;
        @(posedge clk) disable iff (reset)
        rd_en && addr == `DGP_OFS_PB_PIN_READ |=> rd_data[3:0] == 4'h0
        && rd_data[7:4] == ($past(pb_sync) & ~($past(st_r.pb_dir) & ~$past(st_r.pb_ot)));
    endproperty
    a_pb_read: assert property (p_pb_read) else $error("port B pin read wrong"); // [RULE10]

    property p_od_float;
        @(posedge clk) disable iff (reset)
        st_r.pb_ot[0] && st_r.pb_dir[0] |=> portb_pin_oe[4] == !$past(pb_src_o[0]);
    endproperty
    a_od_float: assert property (p_od_float) else $error("open-drain enable wrong"); // [RULE11]

    property p_unimpl;
        @(posedge clk) disable iff (reset)
        rd_en && addr == `DGP_OFS_PB_FUNCTION |=> rd_data[7] == 1'h0 && rd_data[3:0] == 4'h0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits read nonzero"); // [RULE14]

endmodule // dgp_port

`default_nettype wire

/* File: core/dgp_map.svh */
`ifndef DGP_MAP_SVH
`define DGP_MAP_SVH

// -----------------------------------------------------------------
// Register offsets on the internal register bus
// -----------------------------------------------------------------
`define DGP_OFS_P9_LATCH 12'h009
`define DGP_OFS_PB_LATCH 12'h00B
`define DGP_OFS_P9_PIN_READ 12'h016
`define DGP_OFS_PB_PIN_READ 12'h018
`define DGP_OFS_P9_DIRECTION 12'hF23
`define DGP_OFS_PB_DIRECTION 12'hF25
`define DGP_OFS_P9_PULLUP 12'hF30
`define DGP_OFS_P9_FUNCTION 12'hF3D
`define DGP_OFS_PB_FUNCTION 12'hF3F
`define DGP_OFS_P9_OUT_TYPE 12'hF4A
`define DGP_OFS_PB_OUT_TYPE 12'hF4C

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define DGP_P9_LSB 0
`define DGP_P9_MSB 1
`define DGP_PB_LSB 4
`define DGP_PB_MSB 7
`define DGP_PB_FC_MSB 6
`define DGP_RST_2 2'h0
`define DGP_RST_3 3'h0
`define DGP_RST_4 4'h0
`define DGP_RST_8 8'h00

`endif

/* File: core/dgp_pkg.sv */
package dgp_pkg;

    // -----------------------------------------------------------------
    // State of the two-flop pin synchroniser (port 9 low, port B high)
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [5:0] stage1;
        logic [5:0] stage2;
    } dgp_sync_s;

    // -----------------------------------------------------------------
    // State of the port block
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] p9_dir;
        logic [1:0] p9_fc;
        logic [1:0] p9_ot;
        logic [1:0] p9_pu;
        logic [1:0] p9_lat;
        logic [3:0] pb_dir;
        logic [2:0] pb_fc;
        logic [3:0] pb_ot;
        logic [3:0] pb_lat;
        logic [7:0] rd_data;
        logic [1:0] p9_out;
        logic [1:0] p9_oe;
        logic [1:0] p9_pull;
        logic [3:0] pb_out;
        logic [3:0] pb_oe;
        logic [1:0] u2_rx;
        logic [1:0] u1_rx;
        logic si;
    } dgp_state_s;

endpackage

/* File: core/dgp_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module dgp_sync
    import dgp_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous, active high
    input wire logic [5:0] pin_raw, // Asynchronous pin levels
    output logic [5:0] pin_sync // Levels after two flops
);

    dgp_sync_s st_r;
    dgp_sync_s st_nxt;

    // Second flop alone reads the first one
    always_comb
    begin
        st_nxt.stage1 = pin_raw;
        st_nxt.stage2 = st_r.stage1;
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pin_sync = st_r.stage2;

endmodule // dgp_sync

`default_nettype wire

/* File: core/dgp_unused_placeholder_check.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: verif/dgp_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------
// Pin world: order {pb7..pb4, p91, p90}
// ------------------------------------------------
module dgp_pin_model (
    input wire logic clk, // System clock
    input wire logic [5:0] oe, // Port driver on
    input wire logic [5:0] drv, // Port drive level
    input wire logic [5:0] pull, // Pull-up connected
    input wire logic [5:0] ext_en, // Outside party drives
    input wire logic [5:0] ext_val, // Outside drive level
    output logic [5:0] level // Resolved pin level
);
    logic [5:0] drift = 6'h15;

    // Floating pins wander, so a stale value never passes for a match
    always @(posedge clk)
        drift <= ~drift;

    // Port driver wins, then the outside party, then the pull-up
    always_comb
        for (int i = 0; i < 6; i++)
            level[i] = oe[i] ? drv[i] : ext_en[i] ? ext_val[i] : pull[i] ? 1'h1 : drift[i];
endmodule // dgp_pin_model

`default_nettype wire

/* File: verif/dgp_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dgp_map.svh"

module dgp_port_tb;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [11:0] addr = 12'h000;
    logic wr_en = 1'h0;
    logic rd_en = 1'h0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data;
    logic [1:0] p9_in, p9_out, p9_oe, p9_pu, u2_rx, u1_rx;
    logic [7:4] pb_in, pb_out, pb_oe;
    logic u2_tx = 1'h0;
    logic u1_tx = 1'h0;
    logic sclk = 1'h0;
    logic sdo = 1'h0;
    logic sel4 = 1'h0;
    logic sdi;
    logic [5:0] ext_en = 6'h3F;
    logic [5:0] ext_val = 6'h00;
    logic [5:0] level, dir, ot, lat, fc, pu, src, e_drv, e_oe, e_out, e_pull, e_lvl, known, rdm, k, d;
    logic [31:0] r;
    logic [15:0] note;
    logic [15:0] exp_q [$];
    logic rd_seen_r = 1'h0;
    logic [7:0] v [10];
    logic [11:0] ra [10] = '{`DGP_OFS_P9_LATCH, `DGP_OFS_PB_LATCH, `DGP_OFS_P9_DIRECTION, `DGP_OFS_PB_DIRECTION,
        `DGP_OFS_P9_PULLUP, `DGP_OFS_P9_FUNCTION, `DGP_OFS_PB_FUNCTION, `DGP_OFS_P9_OUT_TYPE,
        `DGP_OFS_PB_OUT_TYPE, 12'h0AA};
    logic [7:0] rm [10] = '{8'h03, 8'hF0, 8'h03, 8'hF0, 8'h03, 8'h03, 8'h70, 8'h03, 8'hF0, 8'h00};
    integer fail_count = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    integer seed = 32'hFFF8;

    always #2.5 clk = ~clk;

    dgp_port dgp_port_inst (.clk(clk), .reset(reset), .addr(addr), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .port9_pin_in(p9_in), .port9_pin_out(p9_out), .port9_pin_oe(p9_oe),
        .port9_pullup_on(p9_pu), .portb_pin_in(pb_in), .portb_pin_out(pb_out), .portb_pin_oe(pb_oe),
        .uart_second_transmit(u2_tx), .uart_second_receive(u2_rx), .uart_first_transmit(u1_tx),
        .serial_clock_line(sclk), .serial_data_out(sdo), .portb4_serial_sel(sel4),
        .uart_first_receive(u1_rx), .serial_data_in(sdi));

    dgp_pin_model dgp_pin_model_inst (.clk(clk), .oe({pb_oe, p9_oe}), .drv({pb_out, p9_out}),
        .pull({4'h0, p9_pu}), .ext_en(ext_en), .ext_val(ext_val), .level(level));

    assign p9_in = level[1:0];
    assign pb_in = level[5:2];

    // ------------------------------------------------
    // Comparison, bus and closing tasks
    // ------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access then one idle cycle, so strobes never bounce in one step
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] dv, input logic [7:0] m);
        if (!w)
            exp_q.push_back({m, dv & m});
        addr = a;
        wr_data = dv;
        wr_en = w;
        rd_en = !w;
        @(negedge clk);
        wr_en = 1'h0;
        rd_en = 1'h0;
        @(negedge clk);
    endtask

    task automatic test_done;
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Expected pin behaviour from the current setup
    task automatic expect_pins;
        src = {1'h0, sclk, u1_tx, sel4 ? sdo : u1_tx, u2_tx, u2_tx};
        e_drv = (fc & src) | (~fc & lat);
        e_oe = dir & ~(ot & e_drv);
        e_out = e_drv & ~ot;
        e_pull = pu & (~dir | ot);
        e_lvl = (e_oe & e_out) | (~e_oe & ext_en & ext_val) | (~e_oe & ~ext_en & e_pull);
        known = e_oe | ext_en | e_pull;
        rdm = ~(dir & ~ot);
        k = dir | known;
        d = (dir | e_lvl) & k;
    endtask

    // ------------------------------------------------
    // Read watcher: oldest note against the returned byte
    // ------------------------------------------------
    always @(posedge clk)
        rd_seen_r <= rd_en;

    always @(negedge clk)
    begin
        if (rd_seen_r)
        begin
            note = exp_q.pop_front();
            check(rd_data & note[15:8], note[7:0]);
        end
    end

    // Hang guard, well above the expected run of some 1200 cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            fail_count++;
            test_done();
        end
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        repeat (12) @(negedge clk);
        reset = 1'h0;
        for (int i = 0; i < 10; i++)
            bus(1'h0, ra[i], 8'h00, 8'hFF);
        for (int n = 0; n < 24; n++)
        begin
            for (int i = 0; i < 10; i++)
            begin
                r = $random(seed);
                v[i] = r[7:0];
                bus(1'h1, ra[i], v[i], 8'h00);
            end
            for (int i = 0; i < 10; i++)
                bus(1'h0, ra[i], v[i] & rm[i], 8'hFF);
            lat = {v[1][7:4], v[0][1:0]};
            dir = {v[3][7:4], v[2][1:0]};
            pu = {4'h0, v[4][1:0]};
            fc = {1'h0, v[6][6:4], v[5][1:0]};
            ot = {v[8][7:4], v[7][1:0]};
            r = $random(seed);
            {sel4, sdo, sclk, u1_tx, u2_tx} = r[4:0];
            ext_en = r[10:5] | r[16:11];
            ext_val = r[22:17];
            expect_pins();
            repeat (4) @(negedge clk);
            check({2'h0, pb_oe, p9_oe}, {2'h0, e_oe});
            check({2'h0, pb_out, p9_out}, {2'h0, e_out});
            check({6'h0, p9_pu}, {6'h0, e_pull[1:0]});
            check({3'h0, sdi, u1_rx, u2_rx} & {3'h0, k[3], k[3:0]}, {3'h0, d[3], d[3:0]});
            bus(1'h0, `DGP_OFS_P9_PIN_READ, {6'h0, e_lvl[1:0] & rdm[1:0]}, {6'h3F, known[1:0] | ~rdm[1:0]});
            bus(1'h0, `DGP_OFS_PB_PIN_READ, {e_lvl[5:2] & rdm[5:2], 4'h0}, {known[5:2] | ~rdm[5:2], 4'hF});
        end
        // latch write then read with no idle cycle between
        r = $random(seed);
        addr = `DGP_OFS_PB_LATCH;
        wr_data = r[7:0];
        wr_en = 1'h1;
        @(negedge clk);
        exp_q.push_back({8'hFF, r[7:4], 4'h0});
        wr_en = 1'h0;
        rd_en = 1'h1;
        @(negedge clk);
        rd_en = 1'h0;
        @(negedge clk);
        // two-flop pin delay: second edge still shows the old level
        bus(1'h1, `DGP_OFS_P9_DIRECTION, 8'h00, 8'h00);
        ext_en = 6'h3F;
        ext_val = 6'h00;
        repeat (4) @(negedge clk);
        ext_val = 6'h3F;
        @(negedge clk);
        bus(1'h0, `DGP_OFS_P9_PIN_READ, 8'h00, 8'hFF);
        bus(1'h0, `DGP_OFS_P9_PIN_READ, 8'h03, 8'hFF);
        test_done();
    end
endmodule // dgp_port_tb

`default_nettype wire
